//--- src/flash_cfg_pkg.sv
`default_nettype none
package flash_cfg_pkg;

    // ****************************************
    // Serial commands
    // ****************************************
    localparam logic [7:0] CMD_FAST_READ = 8'h0b;
    localparam logic [7:0] CMD_WRITE_VCFG = 8'h81;
    localparam logic [7:0] CMD_READ_VCFG = 8'h85;

    // ****************************************
    // Configuration register layout
    // ****************************************
    localparam int DUMMY_MSB = 7;
    localparam int DUMMY_LSB = 4;
    localparam int IN_PLACE_BIT = 3;
    localparam int RSVD_BIT = 2;
    localparam int WRAP_MSB = 1;
    localparam int WRAP_LSB = 0;
    localparam logic [7:0] VCFG_RESET = 8'hfb;
    localparam logic [3:0] DUMMY_ZERO = 4'h0;
    localparam logic [3:0] DUMMY_ALL_ONES = 4'hf;
    localparam logic [3:0] DUMMY_DEFAULT = 4'ha;
    localparam logic [1:0] WRAP_16 = 2'b00;
    localparam logic [1:0] WRAP_32 = 2'b01;
    localparam logic [1:0] WRAP_64 = 2'b10;
    localparam logic [1:0] WRAP_SEQ = 2'b11;
    localparam logic [23:0] MASK_16 = 24'h00000f;
    localparam logic [23:0] MASK_32 = 24'h00001f;
    localparam logic [23:0] MASK_64 = 24'h00003f;
    localparam logic [23:0] MASK_SEQ = 24'hffffff;

    // ****************************************
    // Controller registers on the bus
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_WDATA = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_EXIT_BIT = 2;
    localparam int CTRL_LEN_LSB = 8;
    localparam int STATUS_BUSY_BIT = 8;
    localparam int STATUS_CFG_LSB = 16;

    typedef enum logic [1:0] {OP_READ_CFG, OP_WRITE_CFG, OP_FAST_READ, OP_IN_PLACE_READ} host_op_t;

    // Dummy count actually used for a field value
    function automatic logic [3:0] eff_dummy(input logic [3:0] field);
        if (field == DUMMY_ZERO || field == DUMMY_ALL_ONES)
            return DUMMY_DEFAULT;
        return field;
    endfunction

    // Reserved bit forced to zero
    function automatic logic [7:0] clean_cfg(input logic [7:0] value);
        logic [7:0] v;
        v = value;
        v[RSVD_BIT] = 1'b0;
        return v;
    endfunction

endpackage
`default_nettype wire

//--- src/flash_link_if.sv
`default_nettype none
interface flash_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_pin;

    // Released data line is pulled high
    assign miso_pin = miso_oe ? miso : 1'b1;

    modport host (output sclk, output cs_n, output mosi, input miso_pin);
    modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface
`default_nettype wire

//--- src/flash_vcfg_device.sv
// Local design decisions: the placing of the registers and register access over Wishbone.
`default_nettype none
// Notes on behaviour
// - Bits 7:4 give dummy cycles after reads.
// - Field 0000 and 1111 both mean default.
// - Too few dummies gives wrong data silently.
// - Host sets dummies enough for its clock.
// - Bit 3 switches execute-in-place mode.
// - Feature digit 2 or 4 forces execute-in-place.
// - Wrap 00 wraps inside aligned 16 bytes.
// - Wrap 01 wraps inside aligned 32 bytes.
// - Wrap 10 wraps inside aligned 64 bytes.
// - Wrap 11 reads sequentially, the default.
// - Wrap starts at address, loops within block.
// - Writes take effect immediately.
// - Register reached only by its commands.
// - Single-edge host respects frequency per dummy count.
// - Double-edge host respects frequency per dummy count; the host here drives single edge only.
module flash_vcfg_device
    import flash_cfg_pkg::*;
#(
    parameter int FEATURE_DIGIT = 1,
    parameter logic [7:0] FILL = 8'h00
)
(
    input wire logic mclk,
    input wire logic rst_b,
    flash_link_if.device link,
    output logic [3:0] dummy_field,
    output logic execute_in_place,
    output logic [1:0] wrap_field,
    output logic in_place_active
);
    import flash_cfg_pkg::*;

    typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_WRCFG, ST_RDCFG, ST_IGNORE} dev_state_t;

    localparam logic IN_PLACE_FORCED = (FEATURE_DIGIT == 2) || (FEATURE_DIGIT == 4);

    // ****************************************
    // Link synchronisers
    // ****************************************
    logic sclk_m, sclk_s, sclk_d;
    logic cs_m, cs_s, cs_d;
    logic mosi_m, mosi_s;
    logic rise, fall, frame_end;

    // Two flops on every link input, then edge history
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
            mosi_m <= 1'b0;
            mosi_s <= 1'b0;
        end
        else
        begin
            sclk_m <= link.sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            cs_m <= link.cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
            mosi_m <= link.mosi;
            mosi_s <= mosi_m;
        end
    end

    // Edges inside a selected frame
    assign rise = sclk_s & ~sclk_d & ~cs_s;
    assign fall = ~sclk_s & sclk_d & ~cs_s;
    assign frame_end = cs_s & ~cs_d;

    // ****************************************
    // Helpers
    // ****************************************
    // Block mask for the wrap field
    function automatic logic [23:0] wrap_mask(input logic [1:0] w);
        case (w)
            WRAP_16: return MASK_16;
            WRAP_32: return MASK_32;
            WRAP_64: return MASK_64;
            default: return MASK_SEQ;
        endcase
    endfunction

    // Next address, looping inside the aligned block
    function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [1:0] w);
        logic [23:0] m;
        logic [23:0] inc;
        m = wrap_mask(w);
        inc = a + 24'h000001;
        return (a & ~m) | (inc & m);
    endfunction

    // Array contents modelled as a fixed pattern
    function automatic logic [7:0] data_of(input logic [23:0] a);
        return a[7:0] ^ FILL;
    endfunction

    // ****************************************
    // Registers and frame state
    // ****************************************
    logic [7:0] cfg;
    dev_state_t state;
    logic [4:0] cnt;
    logic [7:0] in_sr;
    logic [7:0] bit_in;
    logic [23:0] addr;
    logic [7:0] out_sr;
    logic [2:0] out_cnt;
    logic [4:0] dummy_last;
    logic in_place_keep, saw_dummy;
    logic in_place_on;

    assign bit_in = {in_sr[6:0], mosi_s};
    assign dummy_last = {1'b0, eff_dummy(cfg[DUMMY_MSB:DUMMY_LSB])} - 5'd1;
    assign in_place_on = IN_PLACE_FORCED | ~cfg[IN_PLACE_BIT];

    // Frame sequencer
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_CMD;
            cnt <= 5'd0;
        end
        else if (cs_s)
        begin
            state <= in_place_active ? ST_ADDR : ST_CMD;
            cnt <= 5'd0;
        end
        else if (rise)
        begin
            case (state)
                ST_CMD:
                begin
                    cnt <= cnt + 5'd1;
                    if (cnt == 5'd7)
                    begin
                        cnt <= 5'd0;
                        case (bit_in)
                            CMD_FAST_READ: state <= ST_ADDR;
                            CMD_WRITE_VCFG: state <= ST_WRCFG;
                            CMD_READ_VCFG: state <= ST_RDCFG;
                            default: state <= ST_IGNORE;
                        endcase
                    end
                end
                ST_ADDR:
                begin
                    cnt <= cnt + 5'd1;
                    if (cnt == 5'd23)
                    begin
                        cnt <= 5'd0;
                        state <= ST_DUMMY;
                    end
                end
                ST_DUMMY:
                begin
                    cnt <= cnt + 5'd1;
                    if (cnt == dummy_last)
                    begin
                        cnt <= 5'd0;
                        state <= ST_DATA;
                    end
                end
                ST_WRCFG:
                begin
                    cnt <= cnt + 5'd1;
                    if (cnt == 5'd7)
                        state <= ST_IGNORE;
                end
                default: state <= state;
            endcase
        end
    end

    // Input shifter
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            in_sr <= 8'h00;
        else if (rise)
            in_sr <= bit_in;
    end

    // Configuration register write
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg <= VCFG_RESET;
        else if (rise && state == ST_WRCFG && cnt == 5'd7)
            cfg <= clean_cfg(bit_in);
    end

    // Read address, loaded then stepped per byte
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            addr <= 24'h000000;
        else if (rise && state == ST_ADDR)
            addr <= {addr[22:0], mosi_s};
        else if (fall && state == ST_DATA && out_cnt == 3'd7)
            addr <= next_addr(addr, cfg[WRAP_MSB:WRAP_LSB]);
    end

    // ****************************************
    // Output path
    // ****************************************
    // Bytes shift out MSB first on falling edges; no error flag exists
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_sr <= 8'h00;
            out_cnt <= 3'd0;
            link.miso <= 1'b0;
        end
        else if (cs_s)
        begin
            out_cnt <= 3'd0;
            link.miso <= 1'b0;
        end
        else if (rise && state == ST_CMD && cnt == 5'd7 && bit_in == CMD_READ_VCFG)
            out_sr <= clean_cfg(cfg);
        else if (rise && state == ST_DUMMY && cnt == dummy_last)
            out_sr <= data_of(addr);
        else if (fall && (state == ST_DATA || state == ST_RDCFG))
        begin
            link.miso <= out_sr[7];
            out_cnt <= out_cnt + 3'd1;
            if (out_cnt != 3'd7)
                out_sr <= {out_sr[6:0], 1'b0};
            else if (state == ST_RDCFG)
                out_sr <= clean_cfg(cfg);
            else
                out_sr <= data_of(next_addr(addr, cfg[WRAP_MSB:WRAP_LSB]));
        end
    end

    // Drive the data line only while answering
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            link.miso_oe <= 1'b0;
        else
            link.miso_oe <= ~cs_s & (state == ST_DATA || state == ST_RDCFG);
    end

    // ****************************************
    // Execute-in-place tracking
    // ****************************************
    // First dummy bit low keeps the mode for the next frame
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_place_keep <= 1'b0;
            saw_dummy <= 1'b0;
            in_place_active <= 1'b0;
        end
        else if (frame_end)
        begin
            if (saw_dummy)
                in_place_active <= in_place_keep;
            saw_dummy <= 1'b0;
        end
        else if (rise && state == ST_DUMMY && cnt == 5'd0)
        begin
            in_place_keep <= in_place_on & ~mosi_s;
            saw_dummy <= 1'b1;
        end
    end

    // Configuration views for the user side
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dummy_field <= VCFG_RESET[DUMMY_MSB:DUMMY_LSB];
            execute_in_place <= 1'b0;
            wrap_field <= VCFG_RESET[WRAP_MSB:WRAP_LSB];
        end
        else
        begin
            dummy_field <= cfg[DUMMY_MSB:DUMMY_LSB];
            execute_in_place <= in_place_on;
            wrap_field <= cfg[WRAP_MSB:WRAP_LSB];
        end
    end

endmodule
`default_nettype wire

//--- src/flash_vcfg_host.sv
`default_nettype none
module flash_vcfg_host
    import flash_cfg_pkg::*;
#(
    parameter int SCLK_DIV = 4
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    flash_link_if.host link
);
    import flash_cfg_pkg::*;

    typedef enum {H_IDLE, H_XFER, H_GAP} host_state_t;

    // ****************************************
    // Bus slave
    // ****************************************
    logic [23:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] shadow;
    logic [7:0] rx_byte;
    logic busy;
    logic wr_acc, start;
    host_state_t state;

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign start = wr_acc & (wb_adr_i == REG_CTRL) & wb_sel_i[0] & ~busy;

    // One-wait acknowledge with registered read data
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                REG_ADDR: wb_dat_o <= {8'h00, addr_q};
                REG_WDATA: wb_dat_o <= {24'h000000, wdata_q};
                REG_STATUS: wb_dat_o <= {8'h00, shadow, 7'h00, busy, rx_byte};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Address and write-data registers
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q <= 24'h000000;
            wdata_q <= VCFG_RESET;
        end
        else if (wr_acc && wb_adr_i == REG_ADDR)
            addr_q <= 24'(merge({8'h00, addr_q}, wb_dat_i, wb_sel_i));
        else if (wr_acc && wb_adr_i == REG_WDATA)
            wdata_q <= 8'(merge({24'h000000, wdata_q}, wb_dat_i, wb_sel_i));
    end

    // ****************************************
    // Frame setup
    // ****************************************
    host_op_t op;
    logic [7:0] len;
    logic [3:0] dummy;
    logic [31:0] next_sr;
    logic [5:0] next_tx;
    logic [3:0] next_dummy;
    logic [11:0] next_total;

    assign op = host_op_t'(wb_dat_i[CTRL_OP_LSB +: 2]);
    assign len = (wb_dat_i[CTRL_LEN_LSB +: 8] == 8'h00) ? 8'h01 : wb_dat_i[CTRL_LEN_LSB +: 8];
    assign dummy = eff_dummy(shadow[DUMMY_MSB:DUMMY_LSB]);

    // Bits to send, dummies and total length per order
    always_comb
    begin
        next_sr = {CMD_READ_VCFG, 24'h000000};
        next_tx = 6'd8;
        next_dummy = 4'h0;
        next_total = 12'd16;
        case (op)
            OP_WRITE_CFG:
            begin
                next_sr = {CMD_WRITE_VCFG, clean_cfg(wdata_q), 16'h0000};
                next_tx = 6'd16;
                next_total = 12'd16;
            end
            OP_FAST_READ:
            begin
                next_sr = {CMD_FAST_READ, addr_q};
                next_tx = 6'd32;
                next_dummy = dummy;
                next_total = 12'd32 + {8'h00, dummy} + {1'b0, len, 3'b000};
            end
            OP_IN_PLACE_READ:
            begin
                next_sr = {addr_q, 8'h00};
                next_tx = 6'd24;
                next_dummy = dummy;
                next_total = 12'd24 + {8'h00, dummy} + {1'b0, len, 3'b000};
            end
            default:
            begin
                next_sr = {CMD_READ_VCFG, 24'h000000};
            end
        endcase
    end

    // ****************************************
    // Serial engine
    // ****************************************
    logic [$clog2(SCLK_DIV+1)-1:0] div_cnt;
    logic tick;
    logic [31:0] tx_sr;
    logic [5:0] tx_n;
    logic [3:0] dummy_n;
    logic [11:0] total, bit_idx;
    logic exit_bit;
    logic miso_m, miso_s;

    // Line value for a bit position
    function automatic logic bit_val(input logic [11:0] idx, input logic [31:0] sr, input logic [5:0] n,
                                     input logic ex);
        if (idx < {6'd0, n})
            return sr[31];
        return (idx == {6'd0, n}) ? ex : 1'b0;
    endfunction

    // Two flops on the returning data line
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            miso_m <= 1'b1;
            miso_s <= 1'b1;
        end
        else
        begin
            miso_m <= link.miso_pin;
            miso_s <= miso_m;
        end
    end

    // Half-period divider, link at most 50 MHz single edge only
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            div_cnt <= '0;
        else if (state == H_IDLE || tick)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end
    assign tick = (div_cnt == ($clog2(SCLK_DIV+1))'(SCLK_DIV - 1));

    // Frame sequencer, sampling just before each falling edge of the data phase
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= H_IDLE;
            busy <= 1'b0;
            shadow <= VCFG_RESET;
            rx_byte <= 8'h00;
            tx_sr <= 32'h00000000;
            tx_n <= 6'd0;
            dummy_n <= 4'h0;
            total <= 12'd0;
            bit_idx <= 12'd0;
            exit_bit <= 1'b0;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.mosi <= 1'b0;
        end
        else
        begin
            case (state)
                H_IDLE:
                begin
                    if (start)
                    begin
                        state <= H_XFER;
                        busy <= 1'b1;
                        tx_sr <= next_sr;
                        tx_n <= next_tx;
                        dummy_n <= next_dummy;
                        total <= next_total;
                        bit_idx <= 12'd0;
                        exit_bit <= wb_dat_i[CTRL_EXIT_BIT];
                        link.cs_n <= 1'b0;
                        link.mosi <= next_sr[31];
                        if (op == OP_WRITE_CFG)
                            shadow <= clean_cfg(wdata_q);
                    end
                end
                H_XFER:
                begin
                    if (tick && !link.sclk)
                        link.sclk <= 1'b1;
                    else if (tick)
                    begin
                        link.sclk <= 1'b0;
                        if (bit_idx >= {6'd0, tx_n} + {8'd0, dummy_n})
                            rx_byte <= {rx_byte[6:0], miso_s};
                        tx_sr <= {tx_sr[30:0], 1'b0};
                        link.mosi <= bit_val(bit_idx + 12'd1, {tx_sr[30:0], 1'b0}, tx_n, exit_bit);
                        bit_idx <= bit_idx + 12'd1;
                        if (bit_idx == total - 12'd1)
                        begin
                            state <= H_GAP;
                            link.cs_n <= 1'b1;
                        end
                    end
                end
                H_GAP:
                begin
                    if (tick)
                    begin
                        state <= H_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- verif/flash_link_sva.sv
`default_nettype none
module flash_link_sva (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ****************************************
    // Link clock phases and framing
    // ****************************************
    sequence high_phase;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence low_phase;
        !sclk [*4];
    endsequence

    idle_clock_a: assert property (cs_n |-> !sclk)
        else $error("link clock moved outside a frame");
    high_phase_a: assert property ($rose(sclk) |-> high_phase)
        else $error("high phase length wrong");
    low_phase_a: assert property ($fell(sclk) |-> low_phase)
        else $error("low phase too short");
    frame_start_a: assert property ($fell(cs_n) |-> low_phase ##1 sclk)
        else $error("frame start setup wrong");
    frame_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("select gap too short");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data moved in high phase");

    // ****************************************
    // Device data line
    // ****************************************
    miso_hold_a: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso))
        else $error("device data moved in high phase");
    pin_release_a: assert property (!miso_oe |-> miso_pin)
        else $error("released line not high");
    idle_release_a: assert property (cs_n [*4] |-> !miso_oe)
        else $error("device drove line between frames");
    pin_drive_a: assert property (miso_oe |-> miso_pin == miso)
        else $error("driven line mismatch");
    oe_drop_a: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
        else $error("device kept line after frame");
endmodule
`default_nettype wire

//--- verif/tb_volatile_read_config_register.sv
`default_nettype none
module tb_volatile_read_config_register import flash_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_b, cyc, stb, we, ack, in_place, in_place_act;
    logic [3:0] adr, sel, dfield;
    logic [1:0] wfield;
    logic [31:0] dat, rdat, q;
    logic [7:0] cfgs [4] = '{8'h3c, 8'h0d, 8'hfa, 8'h8b};
    int failures, samples_checked, cycles, rises;

    flash_link_if flash_link_if_inst ();
    flash_vcfg_host flash_vcfg_host_inst (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .link(flash_link_if_inst));
    flash_vcfg_device flash_vcfg_device_inst (.mclk(mclk), .rst_b(rst_b), .link(flash_link_if_inst),
        .dummy_field(dfield), .execute_in_place(in_place), .wrap_field(wfield), .in_place_active(in_place_act));
    flash_link_sva flash_link_sva_inst (.mclk(mclk), .rst_b(rst_b), .sclk(flash_link_if_inst.sclk),
        .cs_n(flash_link_if_inst.cs_n), .mosi(flash_link_if_inst.mosi), .miso(flash_link_if_inst.miso),
        .miso_oe(flash_link_if_inst.miso_oe), .miso_pin(flash_link_if_inst.miso_pin));

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Link clock rises inside a frame
    always @(posedge flash_link_if_inst.sclk)
        if (!flash_link_if_inst.cs_n)
            rises++;

    // Hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            complete_run();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge mclk);
        while (ack !== 1'b1)
            @(posedge mclk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic run(input logic [1:0] op, input logic x, input logic [7:0] n);
        rises = 0;
        wb(1'b1, REG_CTRL, {16'h0, n, 5'h0, x, op});
        do
            wb(1'b0, REG_STATUS, 32'h0);
        while (q[STATUS_BUSY_BIT] !== 1'b0);
    endtask

    // Write the register, check outputs and read back
    task automatic set_cfg(input logic [7:0] v);
        wb(1'b1, REG_WDATA, {24'h0, v});
        run(OP_WRITE_CFG, 1'b0, 8'h1);
        chk(dfield, v[7:4]);
        chk(in_place, !v[3]);
        chk(wfield, v[1:0]);
        run(OP_READ_CFG, 1'b0, 8'h1);
        chk(q[7:0], v & 8'hfb);
    endtask

    // Read n bytes, check last byte and clock count
    task automatic rd(input logic [1:0] op, input logic x, input logic [23:0] a, input logic [7:0] n,
                      input logic [7:0] v);
        logic [23:0] m;
        int d;
        m = v[1:0] == WRAP_16 ? MASK_16 : v[1:0] == WRAP_32 ? MASK_32 : v[1:0] == WRAP_64 ? MASK_64 : MASK_SEQ;
        d = (v[7:4] == DUMMY_ZERO || v[7:4] == DUMMY_ALL_ONES) ? DUMMY_DEFAULT : v[7:4];
        wb(1'b1, REG_ADDR, {8'h0, a});
        run(op, x, n);
        chk(q[7:0], ((a & ~m) | ((a + n - 1) & m)) & 24'hff);
        chk(rises, (op == OP_IN_PLACE_READ ? 0 : 8) + 24 + d + 8 * n);
    endtask

    task automatic complete_run();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {cyc, stb, we, adr, dat, failures, samples_checked, cycles, rises} = '0;
        sel = 4'hf;
        rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chk({dfield, in_place, wfield, in_place_act}, {4'hf, 1'b0, 2'h3, 1'b0});
        wb(1'b0, REG_STATUS, 32'h0);
        chk(q[23:16], 8'hfb);
        wb(1'b0, 4'h1, 32'h0);
        chk(q, 32'h0);
        run(OP_READ_CFG, 1'b0, 8'h1);
        chk(q[7:0], 8'hfb);
        rd(OP_FAST_READ, 1'b1, 24'h00003b, 8'h6, VCFG_RESET);
        foreach (cfgs[i])
        begin
            set_cfg(cfgs[i]);
            rd(OP_FAST_READ, 1'b1, 24'h00003b, 8'h6, cfgs[i]);
        end
        set_cfg(8'h53);
        rd(OP_FAST_READ, 1'b0, 24'h000100, 8'h2, 8'h53);
        chk(in_place_act, 1'b1);
        rd(OP_IN_PLACE_READ, 1'b1, 24'h0000fe, 8'h4, 8'h53);
        chk(in_place_act, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
